// ===== include/jcu_pkg.sv
// Purpose: Shared constants and types for the character UART over the debug link.
// Assumes: 20 MHz system clock; link clock sampled as a plain input.
// Notes: Addresses are full byte addresses on the register port.
package jcu_pkg;
    // ****************************************
    // Register map.
    // ****************************************
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam logic [31:0] CHAR_DATA_PORT_ADDR = 32'hff201000;
    localparam logic [31:0] UART_CONTROL_PORT_ADDR = 32'hff201004;
    localparam logic [31:0] EVENT_STATUS_ADDR = 32'hff201010;
    localparam logic [31:0] EVENT_MASK_ADDR = 32'hff201014;

    // ****************************************
    // Field layout.
    // ****************************************
    localparam int CHAR_W = 8;
    localparam int COUNT_LSB = 16;
    localparam int COUNT_W = 16;
    localparam int RX_VALID_BIT = 15;
    localparam int HOST_TOUCHED_BIT = 10;
    localparam int QUEUE_DEPTH = 64;

    // ****************************************
    // Event bits.
    // ****************************************
    localparam int EVT_W = 3;
    localparam int EVT_RX_ARRIVED = 0;
    localparam int EVT_RX_DROPPED = 1;
    localparam int EVT_TX_DROPPED = 2;
    localparam logic [EVT_W-1:0] EVT_RESET = 3'h0;

    // ****************************************
    // Link framing.
    // ****************************************
    localparam int FRAME_BITS = 9;
    localparam int BIT_CNT_W = 4;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [0:0] {
        LINK_IDLE = 1'b0,
        LINK_SHIFT = 1'b1
    } jcu_link_state_t;
endpackage

// ===== rtl/jcu_queue.sv
// Purpose: Synchronous character queue with count, full and empty.
// Assumes: Single clock; push and pop may happen in the same cycle.
// Notes: The head word is visible combinationally while not empty.
`timescale 1ns/10ps
module jcu_queue #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 64
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic pushValid,
    output logic pushReady,
    input wire logic [WIDTH-1:0] pushData,
    output logic popValid,
    input wire logic popReady,
    output logic [WIDTH-1:0] popData,
    output logic [$clog2(DEPTH):0] count
);
    localparam int PTR_W = $clog2(DEPTH);

    // ****************************************
    // Storage and pointers.
    // ****************************************
    logic [WIDTH-1:0] store [DEPTH];
    logic [PTR_W-1:0] wrPtr;
    logic [PTR_W-1:0] rdPtr;
    logic doPush;
    logic doPop;

    generate
        if (DEPTH < 2 || (1 << PTR_W) != DEPTH) begin : gBadDepth
            $error("Queue depth must be a power of two of at least two.");
        end
    endgenerate

    assign pushReady = (count != (PTR_W+1)'(DEPTH));
    assign popValid = (count != '0);
    assign popData = store[rdPtr];
    assign doPush = pushValid && pushReady;
    assign doPop = popValid && popReady;

    // Writes the incoming word at the tail.
    always_ff @(posedge clk) begin
        if (doPush) begin
            store[wrPtr] <= pushData;
        end
    end

    // Moves the pointers and the fill count.
    always_ff @(posedge clk) begin
        if (reset) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (doPush) begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (doPop) begin
                rdPtr <= rdPtr + 1'b1;
            end
            if (doPush && !doPop) begin
                count <= count + 1'b1;
            end else if (doPop && !doPush) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // jcu_queue

// ===== rtl/jcu_uart.sv
// Purpose: Character UART between a processor register port and a serial debug link.
// Assumes: Register port with one-cycle strobes; link pins are asynchronous to clk.
// Notes: Link frames carry nine bits each way while linkFrame is high.
//
// Behaviour
// - Four 32-bit registers; data at ff201000.
// - Control register sits at ff201004.
// - Receive queue holds up to 64 characters.
// - Character arriving at full receive queue dropped.
// - Data bits 31-16 give receive count.
// - Bit 15 set when receive queue nonempty.
// - Data read pops oldest, reports decremented count.
// - Empty read gives bit 15 zero.
// - Transmit queue holds up to 64 characters.
// - Data write appends bits 7-0 to transmit.
// - Data write leaves receive side untouched.
// - Control bits 31-16 give transmit free slots.
// - Write at full transmit queue is discarded.
// - Control bit 10 sets on host access.
// - Writing one to bit 10 clears it.
`timescale 1ns/10ps
module jcu_uart
    import jcu_pkg::*;
#(
    parameter int DEPTH = jcu_pkg::QUEUE_DEPTH
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [jcu_pkg::ADDR_W-1:0] regAddr,
    input wire logic [jcu_pkg::DATA_W-1:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [jcu_pkg::DATA_W-1:0] regRdData,
    output logic irq,
    input wire logic linkClk,
    input wire logic linkFrame,
    input wire logic linkDataIn,
    output logic linkDataOut
);
    import jcu_pkg::*;

    localparam int CNT_W = $clog2(DEPTH) + 1;

    generate
        if (DEPTH >= (1 << COUNT_W)) begin : gBadCount
            $error("Queue depth does not fit the count field.");
        end
    endgenerate

    // ****************************************
    // Address decode.
    // ****************************************
    logic selData;
    logic selCtrl;
    logic selStat;
    logic selMask;

    assign selData = (regAddr == CHAR_DATA_PORT_ADDR);
    assign selCtrl = (regAddr == UART_CONTROL_PORT_ADDR);
    assign selStat = (regAddr == EVENT_STATUS_ADDR);
    assign selMask = (regAddr == EVENT_MASK_ADDR);

    // ****************************************
    // Queues.
    // ****************************************
    logic rxPushValid;
    logic rxPushReady;
    logic [CHAR_W-1:0] rxPushData;
    logic rxPopValid;
    logic rxPopReady;
    logic [CHAR_W-1:0] rxHead;
    logic [CNT_W-1:0] rxCount;
    logic txPushValid;
    logic txPushReady;
    logic txPopValid;
    logic txPopReady;
    logic [CHAR_W-1:0] txHead;
    logic [CNT_W-1:0] txCount;
    logic [CNT_W-1:0] txFree;

    // Receive side: host to processor.
    jcu_queue #(
        .WIDTH(CHAR_W),
        .DEPTH(DEPTH)
    ) rxQueue (
        .clk(clk),
        .reset(reset),
        .pushValid(rxPushValid),
        .pushReady(rxPushReady),
        .pushData(rxPushData),
        .popValid(rxPopValid),
        .popReady(rxPopReady),
        .popData(rxHead),
        .count(rxCount)
    );

    // Transmit side: processor to host.
    jcu_queue #(
        .WIDTH(CHAR_W),
        .DEPTH(DEPTH)
    ) txQueue (
        .clk(clk),
        .reset(reset),
        .pushValid(txPushValid),
        .pushReady(txPushReady),
        .pushData(regWrData[CHAR_W-1:0]),
        .popValid(txPopValid),
        .popReady(txPopReady),
        .popData(txHead),
        .count(txCount)
    );

    // A data read pops only the receive queue; a data write pushes only the transmit queue.
    assign rxPopReady = regRead && selData;
    assign txPushValid = regWrite && selData;
    assign txFree = CNT_W'(DEPTH) - txCount;

    // ****************************************
    // Link pin synchronisers.
    // ****************************************
    logic [SYNC_STAGES-1:0] clkSync;
    logic [SYNC_STAGES-1:0] frameSync;
    logic [SYNC_STAGES-1:0] dinSync;
    logic clkLast;
    logic frameLast;

    // Two flip-flops on each link pin before any logic reads it.
    always_ff @(posedge clk) begin
        if (reset) begin
            clkSync <= '0;
            frameSync <= '0;
            dinSync <= '0;
        end else begin
            clkSync <= {clkSync[0], linkClk};
            frameSync <= {frameSync[0], linkFrame};
            dinSync <= {dinSync[0], linkDataIn};
        end
    end

    // Holds the previous settled values for edge finding.
    always_ff @(posedge clk) begin
        if (reset) begin
            clkLast <= 1'b0;
            frameLast <= 1'b0;
        end else begin
            clkLast <= clkSync[SYNC_STAGES-1];
            frameLast <= frameSync[SYNC_STAGES-1];
        end
    end

    logic linkRise;
    logic linkFall;
    logic frameStart;
    logic frameEnd;

    assign linkRise = clkSync[SYNC_STAGES-1] && !clkLast;
    assign linkFall = !clkSync[SYNC_STAGES-1] && clkLast;
    assign frameStart = frameSync[SYNC_STAGES-1] && !frameLast;
    assign frameEnd = !frameSync[SYNC_STAGES-1] && frameLast;

    // ****************************************
    // Link framing.
    // ****************************************
    jcu_link_state_t linkState;
    logic [FRAME_BITS-1:0] outShift;
    logic [FRAME_BITS-1:0] inShift;
    logic [BIT_CNT_W-1:0] bitCount;
    logic frameGood;

    assign frameGood = (bitCount == BIT_CNT_W'(FRAME_BITS)) && inShift[FRAME_BITS-1];
    assign txPopReady = (linkState == LINK_IDLE) && frameStart;
    assign rxPushValid = (linkState == LINK_SHIFT) && frameEnd && frameGood;
    assign rxPushData = inShift[CHAR_W-1:0];

    // Walks a frame: load outgoing word at start, shift on link edges, deliver at end.
    always_ff @(posedge clk) begin
        if (reset) begin
            linkState <= LINK_IDLE;
            outShift <= '0;
            inShift <= '0;
            bitCount <= '0;
        end else begin
            case (linkState)
                LINK_IDLE: begin
                    if (frameStart) begin
                        outShift <= {txPopValid, txHead};
                        inShift <= '0;
                        bitCount <= '0;
                        linkState <= LINK_SHIFT;
                    end
                end
                LINK_SHIFT: begin
                    if (frameEnd) begin
                        linkState <= LINK_IDLE;
                    end else begin
                        if (linkRise && bitCount != BIT_CNT_W'(FRAME_BITS)) begin
                            inShift <= {inShift[FRAME_BITS-2:0], dinSync[SYNC_STAGES-1]};
                            bitCount <= bitCount + 1'b1;
                        end
                        if (linkFall) begin
                            outShift <= {outShift[FRAME_BITS-2:0], 1'b0};
                        end
                    end
                end
                default: begin
                    linkState <= LINK_IDLE;
                end
            endcase
        end
    end

    // Drives the most significant outgoing bit, low outside frames.
    always_ff @(posedge clk) begin
        if (reset) begin
            linkDataOut <= 1'b0;
        end else if (linkState == LINK_SHIFT && !frameEnd) begin
            linkDataOut <= outShift[FRAME_BITS-1];
        end else if (linkState == LINK_IDLE && frameStart) begin
            linkDataOut <= txPopValid;
        end else begin
            linkDataOut <= 1'b0;
        end
    end

    // ****************************************
    // Host access flag.
    // ****************************************
    logic hostTouchedFlag;

    // Set by any frame start; cleared by writing one; a set in the same cycle wins.
    always_ff @(posedge clk) begin
        if (reset) begin
            hostTouchedFlag <= 1'b0;
        end else if (frameStart) begin
            hostTouchedFlag <= 1'b1;
        end else if (regWrite && selCtrl && regWrData[HOST_TOUCHED_BIT]) begin
            hostTouchedFlag <= 1'b0;
        end
    end

    // ****************************************
    // Events and interrupt.
    // ****************************************
    logic [EVT_W-1:0] evtStatus;
    logic [EVT_W-1:0] evtMask;
    logic [EVT_W-1:0] evtHit;
    logic [EVT_W-1:0] evtClear;

    assign evtHit[EVT_RX_ARRIVED] = rxPushValid && rxPushReady;
    assign evtHit[EVT_RX_DROPPED] = rxPushValid && !rxPushReady;
    assign evtHit[EVT_TX_DROPPED] = txPushValid && !txPushReady;
    assign evtClear = (regWrite && selStat) ? regWrData[EVT_W-1:0] : '0;

    // Sticky status bits; a new event outweighs a clear in the same cycle.
    always_ff @(posedge clk) begin
        if (reset) begin
            evtStatus <= EVT_RESET;
        end else begin
            evtStatus <= (evtStatus & ~evtClear) | evtHit;
        end
    end

    // Mask register, one enable per event.
    always_ff @(posedge clk) begin
        if (reset) begin
            evtMask <= EVT_RESET;
        end else if (regWrite && selMask) begin
            evtMask <= regWrData[EVT_W-1:0];
        end
    end

    // Level interrupt while any enabled event is pending.
    always_ff @(posedge clk) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(evtStatus & evtMask);
        end
    end

    // ****************************************
    // Read data.
    // ****************************************
    logic [DATA_W-1:0] next_regRdData;

    // Forms the read word; unmapped addresses read zero.
    always_comb begin
        next_regRdData = '0;
        if (selData) begin
            if (rxPopValid) begin
                next_regRdData[COUNT_LSB +: COUNT_W] = COUNT_W'(rxCount - 1'b1);
                next_regRdData[RX_VALID_BIT] = 1'b1;
                next_regRdData[CHAR_W-1:0] = rxHead;
            end else begin
                next_regRdData[RX_VALID_BIT] = 1'b0;
            end
        end else if (selCtrl) begin
            next_regRdData[COUNT_LSB +: COUNT_W] = COUNT_W'(txFree);
            next_regRdData[HOST_TOUCHED_BIT] = hostTouchedFlag;
        end else if (selStat) begin
            next_regRdData[EVT_W-1:0] = evtStatus;
        end else if (selMask) begin
            next_regRdData[EVT_W-1:0] = evtMask;
        end
    end

    // Read data stand in the cycle after the read strobe only.
    always_ff @(posedge clk) begin
        if (reset) begin
            regRdData <= '0;
        end else if (regRead) begin
            regRdData <= next_regRdData;
        end else begin
            regRdData <= '0;
        end
    end
endmodule // jcu_uart

// ===== test/jcu_uart_properties.sv
// Purpose: Port-level checks of the character UART register behaviour.
// Assumes: Bench never runs a link frame while register sequences are in flight.
// Notes: Bound to every jcu_uart instance.
`timescale 1ns/10ps
module jcu_uart_properties #(
    parameter int DEPTH = jcu_pkg::QUEUE_DEPTH
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [jcu_pkg::ADDR_W-1:0] regAddr,
    input wire logic [jcu_pkg::DATA_W-1:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [jcu_pkg::DATA_W-1:0] regRdData,
    input wire logic irq,
    input wire logic linkDataOut
);
    import jcu_pkg::*;
    // ********
    // Decode.
    // ********
    logic dRd;
    logic dWr;
    logic cRd;
    logic cWr;
    assign dRd = regRead && regAddr == CHAR_DATA_PORT_ADDR;
    assign dWr = regWrite && regAddr == CHAR_DATA_PORT_ADDR;
    assign cRd = regRead && regAddr == UART_CONTROL_PORT_ADDR;
    assign cWr = regWrite && regAddr == UART_CONTROL_PORT_ADDR;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // ********
    // Assertions.
    // ********
    empty_read_a: assert property (dRd ##1 !regRdData[RX_VALID_BIT] |-> regRdData == 32'h0)
        else $error("empty read not all zero");
    pop_count_a: assert property (dRd ##1 (dRd && regRdData[15]) ##1 regRdData[15]
        |-> regRdData[31:16] == $past(regRdData[31:16]) - 16'h1) else $error("pop count step wrong");
    rx_keep_a: assert property (dRd ##1 (dWr && regRdData[15]) ##1 dRd ##1 regRdData[15]
        |-> regRdData[31:16] == $past(regRdData[31:16], 2) - 16'h1) else $error("write moved rx count");
    rx_bound_a: assert property (dRd ##1 regRdData[15] |-> regRdData[31:16] < DEPTH)
        else $error("rx count too large");
    free_bound_a: assert property (cRd |=> regRdData[31:16] <= DEPTH)
        else $error("free count too large");
    free_step_a: assert property (cRd ##1 dWr ##1 cRd |=> regRdData[31:16] ==
        ($past(regRdData[31:16], 2) == 16'h0 ? 16'h0 : $past(regRdData[31:16], 2) - 16'h1))
        else $error("free count step wrong");
    flag_clear_a: assert property (cWr && regWrData[HOST_TOUCHED_BIT] ##1 cRd |=> !regRdData[10])
        else $error("host flag not cleared");
    reset_clear_a: assert property ($fell(reset) |-> regRdData == 32'h0 && !irq && !linkDataOut)
        else $error("outputs not cleared by reset");
    cover property (dRd ##1 regRdData[15]);
    cover property (cWr ##1 cRd);
    cover property ($rose(irq));
endmodule // jcu_uart_properties

bind jcu_uart jcu_uart_properties #(.DEPTH(DEPTH)) props (.clk(clk), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .irq(irq),
    .linkDataOut(linkDataOut));

// ===== test/jcu_host_model.sv
// Purpose: Host end of the serial debug link, one frame per go pulse.
// Assumes: Nine-bit frames, valid bit first, link clock 400 ns.
// Notes: Link clock stands low between frames.
`timescale 1ns/10ps
module jcu_host_model (
    input wire logic go,
    input wire logic [8:0] word,
    output logic busy,
    output logic [8:0] heard,
    output logic linkClk,
    output logic linkFrame,
    output logic linkDataIn,
    input wire logic linkDataOut
);
    initial begin
        busy = 1'b0;
        heard = 9'h0;
        linkClk = 1'b0;
        linkFrame = 1'b0;
        linkDataIn = 1'b0;
    end
    // Frames run one at a time, bits taken in order.
    always @(posedge go) begin
        busy = 1'b1;
        #7 linkFrame = 1'b1;
        #400;
        for (int i = 8; i >= 0; i--) begin
            linkDataIn = word[i];
            #200 linkClk = 1'b1;
            #190 heard[i] = linkDataOut;
            #10 linkClk = 1'b0;
        end
        #200 linkFrame = 1'b0;
        linkDataIn = ~linkDataIn;
        #400 busy = 1'b0;
    end
endmodule // jcu_host_model

// ===== test/jcu_uart_bench.sv
// Purpose: Self-checking bench for the character UART.
// Assumes: Register port answers reads one cycle later.
// Notes: Read data is taken at the edge closing its cycle.
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; \
    $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module jcu_uart_bench;
    import jcu_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic go = 1'b0;
    logic irq, linkClk, linkFrame, linkDataIn, linkDataOut, busy;
    logic [31:0] regAddr = 32'h0;
    logic [31:0] regWrData = 32'h0;
    logic [31:0] regRdData, got;
    logic [8:0] word = 9'h0;
    logic [8:0] heard;
    int fail_count = 0;
    int checks = 0;
    int cyc = 0;
    int i;
    localparam logic [31:0] DA = CHAR_DATA_PORT_ADDR;
    localparam logic [31:0] CA = UART_CONTROL_PORT_ADDR;
    localparam logic [31:0] SA = EVENT_STATUS_ADDR;
    jcu_uart #(.DEPTH(64)) dut (.clk(clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .irq(irq), .linkClk(linkClk),
        .linkFrame(linkFrame), .linkDataIn(linkDataIn), .linkDataOut(linkDataOut));
    jcu_host_model host (.go(go), .word(word), .busy(busy), .heard(heard), .linkClk(linkClk),
        .linkFrame(linkFrame), .linkDataIn(linkDataIn), .linkDataOut(linkDataOut));
    // ********
    // Clock, timeout and tasks.
    // ********
    initial begin
        forever #25 clk = ~clk;
    end
    initial begin
        forever begin
            @(posedge clk);
            cyc++;
            if (cyc == 20000) begin
                fail_count++;
                end_sim();
            end
        end
    end
    task automatic end_sim();
        if (fail_count == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic op(input logic w, input logic r, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        got = regRdData;
        regWrite <= w;
        regRead <= r;
        regAddr <= a;
        regWrData <= d;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        op(1'b0, 1'b1, a, 32'h0);
        op(1'b0, 1'b0, 32'h0, 32'h0);
        op(1'b0, 1'b0, 32'h0, 32'h0);
        `CHK(got, e)
    endtask
    task automatic frm(input logic [8:0] w, input logic [8:0] e);
        int n;
        op(1'b0, 1'b0, 32'h0, 32'h0);
        go <= 1'b1;
        word <= w;
        op(1'b0, 1'b0, 32'h0, 32'h0);
        go <= 1'b0;
        n = 0;
        while (busy !== 1'b0 && n < 400) begin
            @(posedge clk);
            n++;
        end
        if (n >= 400) fail_count++;
        `CHK((e[8] ? heard : {heard[8], 8'h0}), e)
    endtask
    function automatic logic [31:0] rxw(input int k);
        return k < 64 ? {16'(63 - k), 8'h80, 8'(k)} : 32'h0;
    endfunction
    // ********
    // Tests.
    // ********
    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        rd(DA, 32'h0);
        rd(CA, 32'h0040_0000);
        frm(9'h141, 9'h000);
        rd(CA, 32'h0040_0400);
        op(1'b1, 1'b0, CA, 32'h0);
        rd(CA, 32'h0040_0400);
        op(1'b1, 1'b0, CA, 32'h400);
        rd(CA, 32'h0040_0000);
        rd(DA, 32'h0000_8041);
        rd(DA, 32'h0);
        op(1'b1, 1'b0, SA, 32'h7);
        op(1'b1, 1'b0, EVENT_MASK_ADDR, 32'h2);
        for (i = 0; i < 65; i++) begin
            frm({1'b1, 8'(i)}, 9'h000);
            if (i == 63) `CHK(irq, 1'b0)
        end
        `CHK(irq, 1'b1)
        rd(SA, 32'h3);
        op(1'b1, 1'b0, SA, 32'h7);
        rd(SA, 32'h0);
        `CHK(irq, 1'b0)
        op(1'b0, 1'b1, DA, 32'h0);
        op(1'b1, 1'b0, DA, 32'h55);
        for (i = 1; i < 68; i++) begin
            op(1'b0, i < 66, DA, 32'h0);
            if (i > 1) `CHK(got, (i == 2 ? 32'h0 : rxw(i - 2)))
        end
        op(1'b0, 1'b1, CA, 32'h0);
        op(1'b1, 1'b0, DA, 32'h0);
        op(1'b0, 1'b1, CA, 32'h0);
        `CHK(got, 32'h003f_0400)
        op(1'b0, 1'b0, 32'h0, 32'h0);
        op(1'b0, 1'b0, 32'h0, 32'h0);
        `CHK(got, 32'h003e_0400)
        for (i = 1; i < 63; i++) op(1'b1, 1'b0, DA, i);
        op(1'b0, 1'b1, CA, 32'h0);
        op(1'b1, 1'b0, DA, 32'hee);
        op(1'b0, 1'b1, CA, 32'h0);
        `CHK(got, 32'h0000_0400)
        op(1'b0, 1'b0, 32'h0, 32'h0);
        op(1'b0, 1'b0, 32'h0, 32'h0);
        `CHK(got, 32'h0000_0400)
        rd(SA, 32'h4);
        rd(EVENT_MASK_ADDR, 32'h2);
        frm(9'h000, 9'h155);
        frm(9'h000, 9'h100);
        rd(CA, 32'h0002_0400);
        rd(32'hff20_1008, 32'h0);
        end_sim();
    end
endmodule // jcu_uart_bench
